// ===== pilc_pkg.sv
// Function
// - Seventeen sources, four non-maskable, rest maskable.
// - Any enabled request may nest, whatever its priority.
// - Source request sets its latch; enabled asks CPU.
// - Maskable requests accepted by fixed priority order.
// - Non-maskable order: software/undefined, then trap, then watchdog.
// - Vectors FFFE, FFFC, FFFA, FFF8, FFF6 down FFE0.
// - Maskable needs master and own enable set.
// - External zero also needs its gate bit.
// - Level eleven shared, select bit picks source.
// - Trap interrupts only when trap select zero.
// - Watchdog interrupts only when watchdog select zero.
// - Software and undefined interrupts have no latch.
// - Latch cleared when its interrupt accepted.
// - Reset clears every request latch.
// - Latches at 3C/3D; writing zero clears.
// - Writing one leaves latch unchanged.
// - Latches are readable by software.
// - Service code edits before re-enabling master.
// - Acceptance stacks master flag then clears it.
// - Master flag is bit zero at 3A.
// - Acceptance takes eight machine cycles.
`default_nettype none
package pilc_pkg;
   localparam logic [7:0] PILC_ADDR_LATCH_LO = 8'h3C;
   localparam logic [7:0] PILC_ADDR_LATCH_HI = 8'h3D;
   localparam logic [7:0] PILC_ADDR_ENABLE_LO = 8'h3A;
   localparam logic [7:0] PILC_ADDR_ENABLE_HI = 8'h3B;
   localparam int PILC_IMF_BIT = 0;
   localparam int PILC_TRAP_BIT = 2;
   localparam int PILC_WDT_BIT = 3;
   localparam int PILC_EXT0_BIT = 4;
   localparam int PILC_SHARED_BIT = 11;
   localparam logic [15:0] PILC_LATCH_RESET = 16'h0000;
   localparam logic [15:0] PILC_ENABLE_RESET = 16'h0000;
   localparam logic [15:0] PILC_VEC_RESET = 16'hFFFE;
   localparam logic [15:0] PILC_VEC_SWI = 16'hFFFC;
   localparam logic [15:0] PILC_VEC_TRAP = 16'hFFFA;
   localparam logic [15:0] PILC_VEC_WDT = 16'hFFF8;
   localparam logic [15:0] PILC_VEC_TOP = 16'hFFF6;
   localparam logic [3:0] PILC_ACCEPT_CYCLES = 4'h8;
   localparam logic [3:0] PILC_STACK_DEPTH = 4'h8;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pilc_sfr_s;

   typedef struct packed {
      logic boundary;
      logic swi;
      logic undef;
      logic ret;
   } pilc_core_s;

   typedef enum logic [2:0] {
      PILC_IDLE = 3'b001,
      PILC_ACCEPT = 3'b010,
      PILC_DONE = 3'b100
   } pilc_state_e;
endpackage
`default_nettype wire

// ===== pilc_prio.sv
`default_nettype none
module pilc_prio
   import pilc_pkg::*;
(
   input wire logic [15:0] pend_in, // Pending and enabled lines.
   output logic found_out, // Some line is pending.
   output logic [3:0] idx_out // Winning latch index.
);
   // Lowest index wins; bits two and three are the non-maskable level.
   always_comb begin
      found_out = 1'b0;
      idx_out = 4'h0;
      for (int i = 15; i >= 2; i--) begin
         if (pend_in[i]) begin
            found_out = 1'b1;
            idx_out = 4'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ===== pilc_top.sv
`default_nettype none
module pilc_top
   import pilc_pkg::*;
(
   input wire logic clock_in, // System clock, 40 MHz.
   input wire logic rst_in, // Asynchronous reset, active high.
   input wire pilc_sfr_s sfr_in, // Register access from the core.
   input wire pilc_core_s core_in, // Core events and return strobe.
   input wire logic [15:0] src_in, // Source request pulses, bits 4..15.
   input wire logic ext3_req_in, // External three request pulse.
   input wire logic trap_req_in, // Address trap event pulse.
   input wire logic wdt_req_in, // Watchdog event pulse.
   input wire logic ext_zero_gate_bit_in, // External zero gate.
   input wire logic level11_source_select_in, // Level eleven selector.
   input wire logic trap_output_select_in, // One routes trap to reset.
   input wire logic watchdog_output_select_in, // One routes wdt to reset.
   output logic [7:0] rdata_out, // Register read data.
   output logic irq_req_out, // Interrupt offered to core.
   output logic [15:0] vector_out, // Vector of accepted interrupt.
   output logic vector_valid_out, // One cycle pulse, acceptance done.
   output logic master_enable_flag_out // Master enable state.
);
   // ************************************************************
   // Registers and state
   // ************************************************************
   logic [15:0] request_latch_reg;
   logic [15:0] source_enable_flag_reg;
   logic master_enable_flag_reg;
   logic [PILC_STACK_DEPTH-1:0] imf_stack_reg;
   pilc_state_e state_reg;
   logic [3:0] count_reg;
   logic [3:0] sel_idx_reg;
   logic sel_direct_reg;
   logic [7:0] rdata_reg;
   logic [15:0] vector_reg;
   logic vector_valid_reg;
   logic irq_req_reg;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [15:0] pend_vec;
   logic found;
   logic [3:0] win_idx;
   logic take_latched;
   logic take_direct;
   logic accept_done;

   // Vector for a latch index; maskable levels step down by two.
   function automatic logic [15:0] pilc_vector(input logic [3:0] idx);
      logic [15:0] v;
      v = PILC_VEC_SWI;
      if (idx == 4'(PILC_TRAP_BIT)) begin
         v = PILC_VEC_TRAP;
      end else if (idx == 4'(PILC_WDT_BIT)) begin
         v = PILC_VEC_WDT;
      end else if (idx >= 4'(PILC_EXT0_BIT)) begin
         v = PILC_VEC_TOP - {11'h000, idx - 4'h4, 1'b0};
      end
      return v;
   endfunction

   // ************************************************************
   // Request capture
   // ************************************************************
   // Only the selected source of level eleven reaches its latch; the
   // other one is dropped, so the selector must be set beforehand.
   always_comb begin
      set_vec = src_in & 16'hF7F0;
      set_vec[PILC_SHARED_BIT] = level11_source_select_in ?
         ext3_req_in : src_in[PILC_SHARED_BIT];
      set_vec[PILC_TRAP_BIT] = trap_req_in & ~trap_output_select_in;
      set_vec[PILC_WDT_BIT] = wdt_req_in & ~watchdog_output_select_in;
   end

   // Software can only write zeros; ones keep the latch as it is.
   always_comb begin
      clr_vec = 16'h0000;
      if (sfr_in.wr && sfr_in.addr == PILC_ADDR_LATCH_LO) begin
         clr_vec[7:2] = ~sfr_in.wdata[7:2];
      end else if (sfr_in.wr && sfr_in.addr == PILC_ADDR_LATCH_HI) begin
         clr_vec[15:8] = ~sfr_in.wdata;
      end
      if (take_latched) begin
         clr_vec[sel_idx_reg] = 1'b1;
      end
   end

   // A new request in the clearing cycle survives: set beats clear.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         request_latch_reg <= PILC_LATCH_RESET;
      end else begin
         request_latch_reg <= (request_latch_reg & ~clr_vec) | set_vec;
      end
   end

   // ************************************************************
   // Enable registers
   // ************************************************************
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         source_enable_flag_reg <= PILC_ENABLE_RESET;
      end else if (sfr_in.wr && sfr_in.addr == PILC_ADDR_ENABLE_LO) begin
         source_enable_flag_reg[7:4] <= sfr_in.wdata[7:4];
      end else if (sfr_in.wr && sfr_in.addr == PILC_ADDR_ENABLE_HI) begin
         source_enable_flag_reg[15:8] <= sfr_in.wdata;
      end
   end

   // Acceptance saves and clears the flag; return pops it back.
   // The stack is a shift register, so nesting deeper than its depth
   // loses the oldest saved flag.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         master_enable_flag_reg <= 1'b0;
         imf_stack_reg <= '0;
      end else if (take_latched || take_direct) begin
         imf_stack_reg <= {imf_stack_reg[PILC_STACK_DEPTH-2:0],
            master_enable_flag_reg};
         master_enable_flag_reg <= 1'b0;
      end else if (core_in.ret) begin
         master_enable_flag_reg <= imf_stack_reg[0];
         imf_stack_reg <= {1'b0, imf_stack_reg[PILC_STACK_DEPTH-1:1]};
      end else if (sfr_in.wr && sfr_in.addr == PILC_ADDR_ENABLE_LO) begin
         master_enable_flag_reg <= sfr_in.wdata[PILC_IMF_BIT];
      end
   end

   // ************************************************************
   // Priority resolution
   // ************************************************************
   // Maskable lines need master and own enable; nesting follows
   // because the service routine may set the master flag again.
   always_comb begin
      pend_vec = request_latch_reg &
         (source_enable_flag_reg & {16{master_enable_flag_reg}});
      pend_vec[PILC_EXT0_BIT] = pend_vec[PILC_EXT0_BIT] &
         ext_zero_gate_bit_in;
      pend_vec[3:2] = request_latch_reg[3:2];
      pend_vec[1:0] = 2'b00;
   end

   pilc_prio u_prio (
      .pend_in(pend_vec),
      .found_out(found),
      .idx_out(win_idx)
   );

   // ************************************************************
   // Acceptance sequence
   // ************************************************************
   assign take_latched = (state_reg == PILC_ACCEPT) && !sel_direct_reg &&
      (count_reg == 4'h0);
   assign take_direct = (state_reg == PILC_ACCEPT) && sel_direct_reg &&
      (count_reg == 4'h0);
   assign accept_done = (state_reg == PILC_ACCEPT) &&
      (count_reg == PILC_ACCEPT_CYCLES - 4'h1);

   // Choice is frozen at the boundary; software and undefined events
   // enter directly with no latch and win over latched ones.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= PILC_IDLE;
         count_reg <= 4'h0;
         sel_idx_reg <= 4'h0;
         sel_direct_reg <= 1'b0;
      end else begin
         case (state_reg)
            PILC_IDLE: begin
               count_reg <= 4'h0;
               if (core_in.boundary && (core_in.swi || core_in.undef)) begin
                  sel_direct_reg <= 1'b1;
                  state_reg <= PILC_ACCEPT;
               end else if (core_in.boundary && found) begin
                  sel_direct_reg <= 1'b0;
                  sel_idx_reg <= win_idx;
                  state_reg <= PILC_ACCEPT;
               end
            end
            PILC_ACCEPT: begin
               count_reg <= count_reg + 4'h1;
               if (accept_done) begin
                  state_reg <= PILC_DONE;
               end
            end
            PILC_DONE: begin
               state_reg <= PILC_IDLE;
            end
            default: begin
               state_reg <= PILC_IDLE;
            end
         endcase
      end
   end

   // Vector appears once the eight cycles have run.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         vector_reg <= PILC_VEC_RESET;
         vector_valid_reg <= 1'b0;
         irq_req_reg <= 1'b0;
      end else begin
         vector_valid_reg <= accept_done;
         irq_req_reg <= found && (state_reg == PILC_IDLE);
         if (accept_done) begin
            vector_reg <= sel_direct_reg ? PILC_VEC_SWI :
               pilc_vector(sel_idx_reg);
         end
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg <= 8'h00;
      end else if (sfr_in.addr == PILC_ADDR_LATCH_LO) begin
         rdata_reg <= {request_latch_reg[7:2], 2'b00};
      end else if (sfr_in.addr == PILC_ADDR_LATCH_HI) begin
         rdata_reg <= request_latch_reg[15:8];
      end else if (sfr_in.addr == PILC_ADDR_ENABLE_LO) begin
         rdata_reg <= {source_enable_flag_reg[7:4], 3'b000,
            master_enable_flag_reg};
      end else if (sfr_in.addr == PILC_ADDR_ENABLE_HI) begin
         rdata_reg <= source_enable_flag_reg[15:8];
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign rdata_out = rdata_reg;
   assign irq_req_out = irq_req_reg;
   assign vector_out = vector_reg;
   assign vector_valid_out = vector_valid_reg;
   assign master_enable_flag_out = master_enable_flag_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_ACCEPT_LEN: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(state_reg == PILC_ACCEPT) |-> ##8 vector_valid_reg)
      else $error("Acceptance did not last eight cycles.");
   AST_LATCH_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
      take_latched && !set_vec[sel_idx_reg] |=>
      !request_latch_reg[$past(sel_idx_reg)])
      else $error("Accepted latch not cleared.");
   AST_IMF_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
      take_latched || take_direct |=> !master_enable_flag_reg)
      else $error("Master flag not cleared on acceptance.");
   AST_NO_SET_BY_WRITE: assert property (@(posedge clock_in)
      disable iff (rst_in)
      set_vec == 16'h0000 |=> (request_latch_reg & ~$past(request_latch_reg))
      == 16'h0000)
      else $error("Latch set without a request.");
   AST_SET: assert property (@(posedge clock_in) disable iff (rst_in)
      set_vec[5] |=> request_latch_reg[5])
      else $error("Request did not set its latch.");
   AST_MASK: assert property (@(posedge clock_in) disable iff (rst_in)
      !master_enable_flag_reg && request_latch_reg[15:4] != 12'h000 &&
      request_latch_reg[3:2] == 2'b00 |-> !found)
      else $error("Maskable request passed a clear master flag.");
   AST_EXT0_GATE: assert property (@(posedge clock_in) disable iff (rst_in)
      !ext_zero_gate_bit_in |-> !pend_vec[PILC_EXT0_BIT])
      else $error("External zero passed a closed gate.");
   AST_TRAP_SEL: assert property (@(posedge clock_in) disable iff (rst_in)
      trap_output_select_in && !request_latch_reg[PILC_TRAP_BIT] |=>
      !request_latch_reg[PILC_TRAP_BIT])
      else $error("Trap latch set while routed to reset.");
   AST_WDT_SEL: assert property (@(posedge clock_in) disable iff (rst_in)
      watchdog_output_select_in && !request_latch_reg[PILC_WDT_BIT] |=>
      !request_latch_reg[PILC_WDT_BIT])
      else $error("Watchdog latch set while routed to reset.");
endmodule
`default_nettype wire

// ===== pilc_core_model.sv
`default_nettype none
// ************************************************************
// Core model: instruction boundaries, direct events, returns.
// ************************************************************
module pilc_core_model
   import pilc_pkg::*;
(
   input wire logic clock_in, // System clock.
   input wire logic rst_in, // Reset, active high.
   input wire logic slow_in, // One spaces boundaries apart.
   input wire logic swi_in, // Software event level.
   input wire logic undef_in, // Undefined opcode event level.
   input wire logic ret_in, // Return request from the bench.
   input wire logic irq_req_in, // Interrupt offered by the block.
   input wire logic vector_valid_in, // Acceptance finished.
   output var pilc_core_s core_out // Core events to the block.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;
   logic [1:0] tick_reg;

   // Boundaries pause while an acceptance runs, since it refuses them.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wait_reg <= 4'h0;
         tick_reg <= 2'h0;
         core_out <= '0;
      end else begin
         tick_reg <= tick_reg + 2'h1;
         core_out.ret <= ret_in;
         core_out.boundary <= 1'b0;
         if (vector_valid_in) begin
            wait_reg <= 4'h2;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
         end else if (!slow_in || tick_reg == 2'h0) begin
            core_out.boundary <= 1'b1;
            core_out.swi <= swi_in;
            core_out.undef <= undef_in;
            if (irq_req_in || swi_in || undef_in) begin
               wait_reg <= 4'hC;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== pilc_top_tb.sv
`default_nettype none
// ************************************************************
// Bench for the interrupt latch controller.
// ************************************************************
module pilc_top_tb
   import pilc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   pilc_sfr_s sfr = '0;
   pilc_core_s core;
   logic [15:0] src = 16'h0000;
   logic ext3 = 1'b0, trap = 1'b0, wdt = 1'b0, gate = 1'b0, sel = 1'b0;
   logic tsel = 1'b1, wsel = 1'b1, slow = 1'b0, swi = 1'b0, und = 1'b0;
   logic ret = 1'b0;
   logic irq, vv, master_enable_flag, rd_d = 0;
   logic [7:0] rdata;
   logic [15:0] vec, m;
   logic [15:0] vq[$];
   logic [7:0] rq[$];
   int bad_count = 0, compares = 0, i;

   // Free running system clock.
   always #12.5 clock_in = ~clock_in;

   pilc_top uut (.clock_in(clock_in), .rst_in(rst_in), .sfr_in(sfr),
      .core_in(core), .src_in(src), .ext3_req_in(ext3),
      .trap_req_in(trap), .wdt_req_in(wdt), .ext_zero_gate_bit_in(gate),
      .level11_source_select_in(sel), .trap_output_select_in(tsel),
      .watchdog_output_select_in(wsel), .rdata_out(rdata),
      .irq_req_out(irq), .vector_out(vec), .vector_valid_out(vv),
      .master_enable_flag_out(master_enable_flag));

   pilc_core_model partner (.clock_in(clock_in), .rst_in(rst_in),
      .slow_in(slow), .swi_in(swi), .undef_in(und), .ret_in(ret),
      .irq_req_in(irq), .vector_valid_in(vv), .core_out(core));

   task automatic cmp(input string n, input logic [15:0] e,
                      input logic [15:0] s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr <= '{1'b1, 1'b0, a, d};
      @(posedge clock_in);
      sfr <= '0;
      @(posedge clock_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      sfr <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock_in);
      sfr <= '0;
      repeat (2) @(posedge clock_in);
   endtask

   task automatic pulse(input logic [15:0] s, input logic e3,
                        input logic t, input logic w);
      src <= s;
      ext3 <= e3;
      trap <= t;
      wdt <= w;
      @(posedge clock_in);
      src <= 16'h0000;
      ext3 <= 1'b0;
      trap <= 1'b0;
      wdt <= 1'b0;
      @(posedge clock_in);
   endtask

   // Bounded wait for the acceptance pulse; direct events drop after it.
   task automatic wait_vv();
      repeat (40) begin
         @(negedge clock_in);
         if (vv === 1'b1) break;
      end
      if (vv !== 1'b1) cmp("vector_valid", 16'h1, 16'h0);
      @(posedge clock_in);
      swi <= 1'b0;
      und <= 1'b0;
   endtask

   task automatic ret_p();
      ret <= 1'b1;
      @(posedge clock_in);
      ret <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask

   task automatic acc();
      wait_vv();
      cmp("imf", 16'h0, {15'h0, master_enable_flag});
      ret_p();
   endtask

   // Each result is matched against the oldest note of its kind.
   always @(posedge clock_in) begin
      if (vv === 1'b1) begin
         if (vq.size() == 0) cmp("vector", 16'h0000, vec);
         else cmp("vector", vq.pop_front(), vec);
      end
      if (rd_d) cmp("rdata", {8'h00, rq.pop_front()}, {8'h00, rdata});
      rd_d <= sfr.rd;
   end

   // A hang counts as a mismatch and ends the run the usual way.
   initial begin
      #(25 * 4000);
      bad_count++;
      end_sim();
   end

   // Main sequence; expected vectors follow from the latch index.
   initial begin
      void'($urandom(32'h4DBB5D95));
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      cmp("vector", 16'hFFFE, vec);
      rd(8'h3C, 8'h00);
      rd(8'h3D, 8'h00);
      rd(8'h3A, 8'h00);
      wr(8'h3C, 8'hFF);
      wr(8'h3D, 8'hFF);
      rd(8'h3C, 8'h00);
      m = 16'h0010 | 16'($urandom() & 32'hFFF0);
      gate <= 1'b1;
      pulse(m, 0, 0, 0);
      rd(8'h3C, m[7:0]);
      rd(8'h3D, m[15:8]);
      i = $urandom() & 32'hFFE0;
      wr(8'h3C, ~(m[7:0] & i[7:0]));
      wr(8'h3D, ~(m[15:8] & i[15:8]));
      m = m & ~i[15:0];
      rd(8'h3C, m[7:0]);
      rd(8'h3D, m[15:8]);
      wr(8'h3B, 8'hFF);
      wr(8'h3A, 8'hF0);
      for (int b = 4; b < 16; b++)
         if (m[b]) vq.push_back(16'hFFFE - 16'(2 * b));
      wr(8'h3A, 8'hF1);
      for (int b = 4; b < 16; b++)
         if (m[b]) acc();
      rd(8'h3C, 8'h00);
      rd(8'h3D, 8'h00);
      wr(8'h3A, 8'h00);
      wr(8'h3B, 8'h00);
      wr(8'h3A, 8'h10);
      gate <= 1'b0;
      wr(8'h3A, 8'h11);
      pulse(16'h0030, 0, 0, 0);
      repeat (30) @(posedge clock_in);
      @(negedge clock_in);
      cmp("irq", 16'h0, {15'h0, irq});
      @(posedge clock_in);
      rd(8'h3C, 8'h30);
      vq.push_back(16'hFFF6);
      gate <= 1'b1;
      // The offer must rise one edge after the gate opens.
      @(posedge clock_in);
      @(negedge clock_in);
      cmp("irq", 16'h1, {15'h0, irq});
      acc();
      wr(8'h3A, 8'h00);
      wr(8'h3C, 8'hDF);
      pulse(16'h0000, 1, 0, 0);
      rd(8'h3D, 8'h00);
      sel <= 1'b1;
      pulse(16'h0000, 1, 0, 0);
      rd(8'h3D, 8'h08);
      wr(8'h3D, 8'hF7);
      pulse(16'h0800, 0, 0, 0);
      rd(8'h3D, 8'h00);
      pulse(16'h0000, 0, 1, 1);
      rd(8'h3C, 8'h00);
      tsel <= 1'b0;
      wsel <= 1'b0;
      vq.push_back(16'hFFFA);
      vq.push_back(16'hFFF8);
      pulse(16'h0000, 0, 1, 1);
      acc();
      acc();
      for (int k = 0; k < 2; k++) begin
         vq.push_back(16'hFFFC);
         swi <= (k == 0);
         und <= (k != 0);
         acc();
      end
      slow <= 1'b1;
      wr(8'h3B, 8'h04);
      wr(8'h3A, 8'h21);
      vq.push_back(16'hFFEA);
      pulse(16'h0400, 0, 0, 0);
      wait_vv();
      vq.push_back(16'hFFF4);
      pulse(16'h0020, 0, 0, 0);
      wr(8'h3A, 8'h21);
      acc();
      ret_p();
      cmp("imf", 16'h1, {15'h0, master_enable_flag});
      pulse(16'h0100, 0, 0, 0);
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      cmp("vector", 16'hFFFE, vec);
      rd(8'h3D, 8'h00);
      rd(8'h3A, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
